// ### src/pspf_consts.svh
/*
 Offsets, field positions, reset values and timing counts of the per-port
 status page. Assumes inclusion by the single design file only.
*/
`ifndef PSPF_CONSTS_SVH
`define PSPF_CONSTS_SVH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define PSPF_ADDR_SEL      8'h00
`define PSPF_ADDR_SPEED    8'h04
`define PSPF_ADDR_STATUS   8'h08
`define PSPF_ADDR_ERRCNT   8'h0C
`define PSPF_ADDR_CTRL     8'h10
`define PSPF_ADDR_LINK     8'h14

// ------------------------------------------------------------
// Fields, encodings, reset values
// ------------------------------------------------------------
`define PSPF_NPORTS        3
`define PSPF_SPD_100       3'h0
`define PSPF_SPD_400       3'h2
`define PSPF_SPD_RSVD      3'h6
`define PSPF_CNT_MAX       8'hFF
`define PSPF_CNT_ONE       8'h01
`define PSPF_RESP_OKAY     2'h0
`define PSPF_RESP_SLVERR   2'h2
`define PSPF_ADDR_W        8

// ------------------------------------------------------------
// Debounce time: 341 ms at 40 MHz
// ------------------------------------------------------------
`define PSPF_DEBOUNCE_MS   341
`define PSPF_CLK_KHZ       40000
`define PSPF_DEBOUNCE_CYC  (`PSPF_DEBOUNCE_MS * `PSPF_CLK_KHZ)

`endif

// ### src/pspf_pkg.sv
/*
 Types for the per-port status page block.
 Assumes the consts header is compiled alongside.
*/
package pspf_pkg;
   // Per-port link attachment mode
   typedef enum logic [1:0] {
      PSPF_MODE_CODED_ONLY,
      PSPF_MODE_DUAL,
      PSPF_MODE_LEGACY_ONLY
   } pspf_mode_t;
   // Per-port power state
   typedef enum logic [1:0] {
      PSPF_PWR_ACTIVE,
      PSPF_PWR_SLEEP,
      PSPF_PWR_STANDBY
   } pspf_pwr_t;
endpackage

// ### src/pspf_port_status.sv
/*
 Per-port status and control page of a three-port serial-bus PHY, with an
 AXI4-Lite slave. Assumes the port state machines outside feed events and
 levels synchronous to SYS_CLK, and that a power reset drives RST_N.
*/
// How it works
// - Hold 3-bit max training speed per port
// - Clamp over-capable writes to port capability
// - Speed latched on new coded connection of any port; dual latches 400
// - Dual ports fixed at 400, writes ignored
// - Reset loads capability; no write below minimum
// - Plug present flag always reads one
// - Read-only capable speed field per port
// - Unstable flag set on failure, W1C
// - Coded active flag only while coded mode
// - Connected, valid, not coded means legacy
// - Saturating 8-bit bad codeword counter
// - Counter clears on local or remote count read
// - Asleep flag; sleep only when permitted
// - Sleep permit sampled from pin at reset
// - Monitor mode shows sleep on data lines
// - Loop block flag set by loop-free build
// - Loop block cleared on bus reset, disconnect
// - Standby flag reflects standby state
// - Deep disable acts only on disabled port
// - Deep disable forces connection, valid to zero
// - Deep disable stops tones; leaving it forces renegotiation
// - Connection debounced 341 ms; bus reset keeps
// - Port disable blocks activation; hw reset clears
`timescale 1ns/1ps
`include "pspf_consts.svh"
`default_nettype none

module pspf_port_status #(
   parameter int unsigned DEBOUNCE_CYC = `PSPF_DEBOUNCE_CYC
) (
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   // AXI4-Lite write address
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output var  logic        S_AXI_AWREADY,
   // AXI4-Lite write data
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output var  logic        S_AXI_WREADY,
   // AXI4-Lite write response
   output var  logic [1:0]  S_AXI_BRESP,
   output var  logic        S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   // AXI4-Lite read
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output var  logic        S_AXI_ARREADY,
   output var  logic [31:0] S_AXI_RDATA,
   output var  logic [1:0]  S_AXI_RRESP,
   output var  logic        S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // Port straps and configuration
   input  wire logic [5:0]  PORT_CAP_SPEED,
   input  wire logic [5:0]  PORT_MODE,
   input  wire logic        SLEEP_PERMIT_PIN,
   input  wire logic        POWER_MONITOR_MODE,
   // Port state machine events and levels
   input  wire logic        BUS_RESET,
   input  wire logic [2:0]  RAW_CONNECT,
   input  wire logic [2:0]  RAW_RECEIVE_VALID,
   input  wire logic [2:0]  CODED_LINK_UP,
   input  wire logic [2:0]  NEW_CODED_CONNECT,
   input  wire logic [2:0]  NEGOTIATION_FAIL,
   input  wire logic [2:0]  BAD_CODEWORD,
   input  wire logic [2:0]  SLEEP_REQUEST,
   input  wire logic [2:0]  SLEEP_EXIT,
   input  wire logic [2:0]  STANDBY_STATE,
   input  wire logic [2:0]  LOOP_BLOCK_SET,
   input  wire logic [2:0]  REMOTE_READ_ERRCNT,
   // Outputs to the port machines
   output var  logic [2:0]  PORT_ACTIVE,
   output var  logic [2:0]  LEGACY_ACTIVE,
   output var  logic [2:0]  TONE_ENABLE,
   output var  logic [2:0]  RENEGOTIATE,
   output var  logic [8:0]  TRAIN_SPEED,
   output var  logic [2:0]  LINK_MONITOR_DATA
);

   // ------------------------------------------------------------
   // Per-port state
   // ------------------------------------------------------------
   logic [2:0]  sel;                     // Selected port
   logic [2:0]  max_training_speed [3];  // Allowed coded speed
   logic [2:0]  train_speed [3];         // Speed latched at connect
   logic [7:0]  bad_codeword_count [3];  // Saturating error count
   logic [2:0]  link_unstable_flag;      // Sticky failure flag
   logic [2:0]  port_asleep;             // Sleep state
   logic [2:0]  sleep_permit;            // Sleep allowed
   logic [2:0]  loop_block_state;        // Loop-free block
   logic [2:0]  deep_disable;            // Deep disable control
   logic [2:0]  port_disable;            // Port disable control
   logic [2:0]  con;                     // Debounced connection
   logic [31:0] deb_cnt [3];             // Debounce counters
   logic [2:0]  deep_prev;               // Deep-disable history
   logic        strap_done;              // Pin sampled once

   // ------------------------------------------------------------
   // Bus channel state
   // ------------------------------------------------------------
   logic        aw_held;
   logic [7:0]  aw_addr;
   logic        w_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;

   // Clamp a written speed to capability and the minimum
   function automatic logic [2:0] clamp_speed(input logic [2:0] wr,
                                             input logic [2:0] cap);
      if (wr > cap || wr == `PSPF_SPD_RSVD)
         clamp_speed = cap;
      else
         clamp_speed = wr;
   endfunction

   // Select a port's 2-bit field from a packed vector, zero-extended to 3 bits
   function automatic logic [2:0] port_field(input logic [5:0] vec,
                                            input int unsigned p);
      port_field = (p == 0) ? {1'b0, vec[1:0]} : 3'h0;
      port_field = {1'b0, vec[2*p +: 2]};
   endfunction

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire       wr_go   = aw_held && w_held && !S_AXI_BVALID;
   wire       rd_go   = S_AXI_ARVALID && S_AXI_ARREADY;
   wire [1:0] sp      = (sel < 3'h3) ? sel[1:0] : 2'h0;
   wire       wr_sel  = wr_go && aw_addr == `PSPF_ADDR_SEL;
   wire       wr_spd  = wr_go && aw_addr == `PSPF_ADDR_SPEED;
   wire       wr_sts  = wr_go && aw_addr == `PSPF_ADDR_STATUS;
   wire       wr_ctl  = wr_go && aw_addr == `PSPF_ADDR_CTRL;
   wire       rd_err  = rd_go && S_AXI_ARADDR == `PSPF_ADDR_ERRCNT;
   wire       wr_ok   = wr_sel || wr_spd || wr_sts || wr_ctl;
   wire [2:0] cap_sel = port_field(PORT_CAP_SPEED, sp);
   wire [1:0] mode_sel = PORT_MODE[2*sp +: 2];

   // Effective connection and receive-valid after deep disable
   wire [2:0] deep_on = deep_disable & port_disable;
   wire [2:0] rx_valid = RAW_RECEIVE_VALID & ~deep_on;
   wire [2:0] coded   = CODED_LINK_UP & con & rx_valid;

   // Read mux
   logic [31:0] rd_mux;
   logic        rd_hit;
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      if (S_AXI_ARADDR == `PSPF_ADDR_SEL) begin
         rd_mux = {29'h0, sel};
      end else if (S_AXI_ARADDR == `PSPF_ADDR_SPEED) begin
         rd_mux = {25'h0, cap_sel, 1'b1, max_training_speed[sp]};
      end else if (S_AXI_ARADDR == `PSPF_ADDR_STATUS) begin
         rd_mux = {25'h0, STANDBY_STATE[sp], loop_block_state[sp],
                   port_asleep[sp], rx_valid[sp], con[sp], coded[sp],
                   link_unstable_flag[sp]};
      end else if (S_AXI_ARADDR == `PSPF_ADDR_ERRCNT) begin
         rd_mux = {24'h0, bad_codeword_count[sp]};
      end else if (S_AXI_ARADDR == `PSPF_ADDR_CTRL) begin
         rd_mux = {29'h0, port_disable[sp], deep_disable[sp], sleep_permit[sp]};
      end else if (S_AXI_ARADDR == `PSPF_ADDR_LINK) begin
         rd_mux = {29'h0, LEGACY_ACTIVE[sp], PORT_ACTIVE[sp], coded[sp]};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite handshake
   // ------------------------------------------------------------
   // Address and data are held until both arrive, in either order
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
      end
   end

   // Ready and response flops
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= `PSPF_RESP_OKAY;
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h0000_0000;
         S_AXI_RRESP   <= `PSPF_RESP_OKAY;
      end else begin
         // One cycle ready pulses; each only when its own channel holds nothing
         S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY && S_AXI_AWVALID;
         S_AXI_WREADY  <= !w_held && !S_AXI_WREADY && S_AXI_WVALID;
         if (wr_go) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_ok ? `PSPF_RESP_OKAY : `PSPF_RESP_SLVERR;
         end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
         S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
         if (rd_go) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_mux;
            S_AXI_RRESP  <= rd_hit ? `PSPF_RESP_OKAY : `PSPF_RESP_SLVERR;
         end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Port select and sleep-permit strap
   // ------------------------------------------------------------
   // Pin is caught by the first clocked cycle after reset release
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         sel        <= 3'h0;
         strap_done <= 1'b0;
      end else begin
         strap_done <= 1'b1;
         if (wr_sel && w_strb[0]) begin
            sel <= w_data[2:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Per-port fields
   // ------------------------------------------------------------
   for (genvar p = 0; p < `PSPF_NPORTS; p++) begin : g_port
      wire       me     = (sp == 2'(p));
      wire [2:0] cap    = port_field(PORT_CAP_SPEED, p);
      wire       dual   = PORT_MODE[2*p +: 2] == pspf_pkg::PSPF_MODE_DUAL;
      wire       raw_ok = RAW_CONNECT[p] && !deep_on[p];
      wire       err_rd = (rd_err && me) || REMOTE_READ_ERRCNT[p];

      // Speed, training latch, failure flag
      always_ff @(posedge SYS_CLK) begin
         if (!RST_N) begin
            max_training_speed[p] <= `PSPF_SPD_100;
            train_speed[p]        <= `PSPF_SPD_100;
            link_unstable_flag[p] <= 1'b0;
         end else begin
            if (!strap_done) begin
               max_training_speed[p] <= dual ? `PSPF_SPD_400 : cap;
            end else if (wr_spd && me && w_strb[0] && !dual) begin
               max_training_speed[p] <= clamp_speed(w_data[2:0], cap);
            end
            if (NEW_CODED_CONNECT[p]) begin
               train_speed[p] <= dual ? `PSPF_SPD_400
                                      : max_training_speed[p];
            end
            // Set wins over clear
            if (NEGOTIATION_FAIL[p]) begin
               link_unstable_flag[p] <= 1'b1;
            end else if (wr_sts && me && w_strb[0] && w_data[0]) begin
               link_unstable_flag[p] <= 1'b0;
            end
         end
      end

      // Error counter: an increment in the read cycle is kept
      always_ff @(posedge SYS_CLK) begin
         if (!RST_N) begin
            bad_codeword_count[p] <= 8'h00;
         end else if (err_rd) begin
            bad_codeword_count[p] <= BAD_CODEWORD[p] ? `PSPF_CNT_ONE : 8'h00;
         end else if (BAD_CODEWORD[p] && bad_codeword_count[p] != `PSPF_CNT_MAX) begin
            bad_codeword_count[p] <= bad_codeword_count[p] + `PSPF_CNT_ONE;
         end
      end

      // Controls, sleep and loop state
      always_ff @(posedge SYS_CLK) begin
         if (!RST_N) begin
            sleep_permit[p]     <= 1'b0;
            port_disable[p]     <= 1'b0;
            deep_disable[p]     <= 1'b0;
            port_asleep[p]      <= 1'b0;
            loop_block_state[p] <= 1'b0;
         end else begin
            if (!strap_done) begin
               sleep_permit[p] <= SLEEP_PERMIT_PIN;
            end else if (wr_ctl && me && w_strb[0]) begin
               sleep_permit[p] <= w_data[0];
               deep_disable[p] <= w_data[1];
               port_disable[p] <= w_data[2];
            end
            if (SLEEP_EXIT[p]) begin
               port_asleep[p] <= 1'b0;
            end else if (SLEEP_REQUEST[p] && sleep_permit[p]) begin
               port_asleep[p] <= 1'b1;
            end
            if (BUS_RESET || !con[p]) begin
               loop_block_state[p] <= 1'b0;
            end else if (LOOP_BLOCK_SET[p]) begin
               loop_block_state[p] <= 1'b1;
            end
         end
      end

      // Debounce: bus reset does not touch it
      always_ff @(posedge SYS_CLK) begin
         if (!RST_N) begin
            deb_cnt[p] <= 32'h0000_0000;
            con[p]     <= 1'b0;
         end else if (!raw_ok) begin
            deb_cnt[p] <= 32'h0000_0000;
            con[p]     <= 1'b0;
         end else if (deb_cnt[p] >= DEBOUNCE_CYC - 1) begin
            con[p]     <= 1'b1;
         end else begin
            deb_cnt[p] <= deb_cnt[p] + 32'h0000_0001;
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs to the port machines
   // ------------------------------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         PORT_ACTIVE       <= 3'h0;
         LEGACY_ACTIVE     <= 3'h0;
         TONE_ENABLE       <= 3'h0;
         RENEGOTIATE       <= 3'h0;
         TRAIN_SPEED       <= 9'h000;
         LINK_MONITOR_DATA <= 3'h0;
         deep_prev         <= 3'h0;
      end else begin
         PORT_ACTIVE   <= con & rx_valid & ~port_disable;
         LEGACY_ACTIVE <= con & rx_valid & ~coded & ~port_disable;
         TONE_ENABLE   <= ~deep_on;
         deep_prev     <= deep_on;
         RENEGOTIATE   <= deep_prev & ~deep_on;
         TRAIN_SPEED   <= {train_speed[2], train_speed[1], train_speed[0]};
         LINK_MONITOR_DATA <= POWER_MONITOR_MODE ? port_asleep : 3'h0;
      end
   end

endmodule

`default_nettype wire

// ### bench/pspf_host_model.sv
/* Link-controller model: AXI4-Lite master tasks wr and rd.
   Assumes one call at a time, made after reset release. */
`timescale 1ns/1ps
`default_nettype none
module pspf_host_model (
   // Clock
   input  wire logic        SYS_CLK,
   // Write channels
   output var  logic [7:0]  S_AXI_AWADDR,
   output var  logic        S_AXI_AWVALID,
   input  wire logic        S_AXI_AWREADY,
   output var  logic [31:0] S_AXI_WDATA,
   output var  logic [3:0]  S_AXI_WSTRB,
   output var  logic        S_AXI_WVALID,
   input  wire logic        S_AXI_WREADY,
   input  wire logic [1:0]  S_AXI_BRESP,
   input  wire logic        S_AXI_BVALID,
   output var  logic        S_AXI_BREADY,
   // Read channels
   output var  logic [7:0]  S_AXI_ARADDR,
   output var  logic        S_AXI_ARVALID,
   input  wire logic        S_AXI_ARREADY,
   input  wire logic [31:0] S_AXI_RDATA,
   input  wire logic [1:0]  S_AXI_RRESP,
   input  wire logic        S_AXI_RVALID,
   output var  logic        S_AXI_RREADY
);
   // Idle bus from time zero
   initial begin
      {S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WSTRB} = '0;
      {S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} = '0;
   end
   // Write: both channels offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge SYS_CLK);
      S_AXI_AWADDR  <= a;
      S_AXI_WDATA   <= d;
      S_AXI_WSTRB   <= 4'hF;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID  <= 1'b1;
      S_AXI_BREADY  <= 1'b1;
      do begin
         @(posedge SYS_CLK);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         // Released data no longer shows the old word
         if (S_AXI_WREADY) S_AXI_WDATA <= ~d;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end while (!S_AXI_BVALID);
      r = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
   endtask
   // Read: address dropped when taken, data taken with rvalid
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge SYS_CLK);
      S_AXI_ARADDR  <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY  <= 1'b1;
      do begin
         @(posedge SYS_CLK);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end while (!S_AXI_RVALID);
      d = S_AXI_RDATA;
      r = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### bench/pspf_port_status_chk.sv
/* Port-level checker for the status page block.
   Assumes binding to pspf_port_status; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module pspf_port_status_chk (
   // Clock and reset
   input wire logic       SYS_CLK,
   input wire logic       RST_N,
   // Bus handshakes
   input wire logic       S_AXI_AWREADY,
   input wire logic       S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic       S_AXI_BVALID,
   input wire logic       S_AXI_BREADY,
   input wire logic       S_AXI_ARVALID,
   input wire logic       S_AXI_ARREADY,
   input wire logic       S_AXI_RVALID,
   // Port side
   input wire logic [2:0] NEW_CODED_CONNECT,
   input wire logic       POWER_MONITOR_MODE,
   input wire logic [2:0] PORT_ACTIVE,
   input wire logic [2:0] LEGACY_ACTIVE,
   input wire logic [2:0] RENEGOTIATE,
   input wire logic [8:0] TRAIN_SPEED,
   input wire logic [2:0] LINK_MONITOR_DATA
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   // ------------------------------------------------------------
   // Register bus answers
   // ------------------------------------------------------------
   a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
      S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
   a_write_answer: assert property (S_AXI_AWREADY && S_AXI_WREADY |->
      ##[1:4] S_AXI_BVALID) else $error("write response late");
   a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |->
      ##[1:4] S_AXI_RVALID) else $error("read data late");
   // ------------------------------------------------------------
   // Port outputs
   // ------------------------------------------------------------
   a_legacy_sub: assert property ((LEGACY_ACTIVE & ~PORT_ACTIVE) == 3'h0)
      else $error("legacy without active");
   a_monitor_off: assert property (!$past(POWER_MONITOR_MODE) |->
      LINK_MONITOR_DATA == 3'h0) else $error("monitor lines busy");
   a_renego_pulse: assert property ((RENEGOTIATE & $past(RENEGOTIATE)) == 3'h0)
      else $error("renegotiate too long");
   a_train_hold: assert property ($past(NEW_CODED_CONNECT) == 3'h0 |=>
      $stable(TRAIN_SPEED)) else $error("speed moved without connect");
   a_speed_legal: assert property ((TRAIN_SPEED & 9'h124) == 9'h000)
      else $error("speed above capability");
endmodule
bind pspf_port_status pspf_port_status_chk u_chk (.*);
`default_nettype wire

// ### bench/pspf_port_status_tb_top.sv
/* Self-checking bench of the status page block.
   Assumes the host model and checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module pspf_port_status_tb_top;
   // Stimulus and straps
   logic       SYS_CLK = 1'b0;
   logic       RST_N = 1'b0;
   logic [5:0] PORT_CAP_SPEED = 6'h00;
   logic [5:0] PORT_MODE = 6'h04;   // Port 1 dual, others coded only
   logic       SLEEP_PERMIT_PIN = 1'b1;
   logic       POWER_MONITOR_MODE = 1'b0;
   logic       BUS_RESET = 1'b0;
   logic [2:0] RAW_CONNECT = 3'h0;
   logic [2:0] RAW_RECEIVE_VALID = 3'h0;
   logic [2:0] CODED_LINK_UP = 3'h0;
   logic [2:0] STANDBY_STATE = 3'h0;
   logic [2:0] ev [0:6] = '{default: 3'h0};   // Event pulses by kind
   logic [2:0] cap [0:2];                      // Random capability per port
   logic       reneg = 1'b0;                   // Renegotiate seen on port 2
   int         n_mismatch = 0;
   int         n_compared = 0;
   int         cyc = 0;
   // Event kinds
   wire logic [2:0] NEGOTIATION_FAIL = ev[0];
   wire logic [2:0] BAD_CODEWORD = ev[1];
   wire logic [2:0] SLEEP_REQUEST = ev[2];
   wire logic [2:0] SLEEP_EXIT = ev[3];
   wire logic [2:0] LOOP_BLOCK_SET = ev[4];
   wire logic [2:0] REMOTE_READ_ERRCNT = ev[5];
   wire logic [2:0] NEW_CODED_CONNECT = ev[6];
   // Bus and outputs
   wire logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
   wire logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
   wire logic [3:0]  S_AXI_WSTRB;
   wire logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
   wire logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
   wire logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
   wire logic        S_AXI_RVALID, S_AXI_RREADY;
   wire logic [2:0]  PORT_ACTIVE, LEGACY_ACTIVE, TONE_ENABLE, RENEGOTIATE, LINK_MONITOR_DATA;
   wire logic [8:0]  TRAIN_SPEED;
   // Short debounce keeps the run brief
   pspf_port_status #(.DEBOUNCE_CYC(20)) u_dut (.*);
   pspf_host_model u_host (.*);
   always #12.5 SYS_CLK = ~SYS_CLK;
   // Catch renegotiation pulses, which last one cycle
   always @(posedge SYS_CLK) if (RENEGOTIATE[2]) reneg <= 1'b1;
   // Hang guard
   always @(posedge SYS_CLK) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch at %0t ns: seen %h, expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      u_host.wr(a, d, r);
   endtask
   // Masked register read against an expectation
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] v;
      logic [1:0]  r;
      u_host.rd(a, v, r);
      chk(v & m, e);
   endtask
   task automatic pulse(input int k, input int p);
      @(posedge SYS_CLK);
      ev[k][p] <= 1'b1;
      @(posedge SYS_CLK);
      ev[k][p] <= 1'b0;
   endtask
   // Stored speed: dual port pinned at 400, others clamp to capability
   function automatic logic [2:0] exp_spd(input int p, input logic [2:0] w);
      if (p == 1) return 3'h2;
      return (w > cap[p]) ? cap[p] : w;
   endfunction
   initial begin
      logic [31:0] v;
      logic [1:0]  r;
      int          n;
      void'($urandom(6));
      for (int p = 0; p < 3; p++)
         cap[p] = 3'($urandom_range(3, 0));
      @(posedge SYS_CLK);
      PORT_CAP_SPEED <= {cap[2][1:0], cap[1][1:0], cap[0][1:0]};
      repeat (11) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      repeat (3) @(posedge SYS_CLK);
      // Reset values per port
      for (int p = 0; p < 3; p++) begin
         wr(8'h00, p);
         rdc(8'h04, 32'h7F, {25'h0, cap[p], 1'b1, exp_spd(p, 3'h7)});
         rdc(8'h10, 32'h1, 32'h1);
      end
      // Every speed code, including reserved ones
      for (int p = 0; p < 2; p++) begin
         wr(8'h00, p);
         for (int w = 0; w < 8; w++) begin
            wr(8'h04, w);
            rdc(8'h04, 32'h7, {29'h0, exp_spd(p, 3'(w))});
         end
      end
      wr(8'h00, 0);
      wr(8'h04, 0);
      pulse(6, 0);
      pulse(6, 1);
      repeat (2) @(posedge SYS_CLK);
      chk(TRAIN_SPEED[5:0], 6'h10);
      // Status flags on port 0, connected so coded and loop flags can rise
      RAW_CONNECT <= 3'h1;
      RAW_RECEIVE_VALID <= 3'h1;
      repeat (20) @(posedge SYS_CLK);
      pulse(0, 0);
      rdc(8'h08, 32'h1, 32'h1);
      wr(8'h08, 32'h1);
      rdc(8'h08, 32'h1, 32'h0);
      CODED_LINK_UP <= 3'h1;
      STANDBY_STATE <= 3'h1;
      rdc(8'h08, 32'h42, 32'h42);
      CODED_LINK_UP <= 3'h0;
      STANDBY_STATE <= 3'h0;
      rdc(8'h08, 32'h42, 32'h0);
      pulse(4, 0);
      rdc(8'h08, 32'h20, 32'h20);
      BUS_RESET <= 1'b1;
      @(posedge SYS_CLK);
      BUS_RESET <= 1'b0;
      rdc(8'h08, 32'h24, 32'h4);
      // Sleep permitted on port 0, not on port 1
      wr(8'h00, 1);
      wr(8'h10, 32'h0);
      POWER_MONITOR_MODE <= 1'b1;
      pulse(2, 0);
      pulse(2, 1);
      rdc(8'h08, 32'h10, 32'h0);
      wr(8'h00, 0);
      rdc(8'h08, 32'h10, 32'h10);
      chk(LINK_MONITOR_DATA, 3'h1);
      pulse(3, 0);
      repeat (3) @(posedge SYS_CLK);
      chk(LINK_MONITOR_DATA, 3'h0);
      // Error counter on port 2
      wr(8'h00, 2);
      n = $urandom_range(40, 1);
      repeat (n) pulse(1, 2);
      rdc(8'h0C, 32'hFF, n);
      rdc(8'h0C, 32'hFF, 32'h0);
      repeat (260) pulse(1, 2);
      rdc(8'h0C, 32'hFF, 32'hFF);
      pulse(1, 2);
      pulse(5, 2);
      rdc(8'h0C, 32'hFF, 32'h0);
      // Connection, disable and deep disable on port 2
      RAW_CONNECT <= 3'h4;
      RAW_RECEIVE_VALID <= 3'h4;
      rdc(8'h08, 32'h4, 32'h0);
      repeat (40) @(posedge SYS_CLK);
      rdc(8'h08, 32'hC, 32'hC);
      chk(LEGACY_ACTIVE, 3'h4);
      wr(8'h10, 32'h3);
      rdc(8'h08, 32'hC, 32'hC);
      chk(TONE_ENABLE[2], 1'b1);
      wr(8'h10, 32'h5);
      rdc(8'h14, 32'h6, 32'h0);
      chk(PORT_ACTIVE[2], 1'b0);
      wr(8'h10, 32'h7);
      rdc(8'h08, 32'hC, 32'h0);
      chk(TONE_ENABLE[2], 1'b0);
      wr(8'h10, 32'h1);
      repeat (4) @(posedge SYS_CLK);
      chk(reneg, 1'b1);
      // Unmapped addresses
      u_host.rd(8'h18, v, r);
      chk(r, 2'h2);
      chk(v, 32'h0);
      u_host.wr(8'h1C, 32'h1, r);
      chk(r, 2'h2);
      print_verdict();
   end
endmodule
`default_nettype wire
